// file: design/gmt_params.svh
`ifndef GMT_PARAMS_SVH
`define GMT_PARAMS_SVH

// =====================================================================
// register indices, byte address is four times the index
`define GMT_IDX_MODE_CFG   6'h18
`define GMT_IDX_TDRV_A     6'h19
`define GMT_IDX_TDRV_B     6'h1a
`define GMT_IDX_DEAD_CFG   6'h1b
`define GMT_IDX_STATUS     6'h20
`define GMT_IDX_MASK       6'h21
`define GMT_IDX_FAULT_CLR  6'h22
`define GMT_IDX_PAIRING    6'h23

// =====================================================================
// field positions
`define GMT_TDRV_HI_LSB    3
`define GMT_TDRV_LO_LSB    0
`define GMT_STAT_OC_LSB    4
`define GMT_PAIR_BIT       0

// =====================================================================
// reset values
`define GMT_RST_MODE_CFG   8'h00
`define GMT_RST_TDRV       8'h12
`define GMT_RST_DEAD       8'h00
`define GMT_RST_MASK       8'h00

// =====================================================================
// timing, times in microseconds
`define GMT_CLK_MHZ        10
`define GMT_US2CYC(us)     ((us) * `GMT_CLK_MHZ)
`define GMT_TDRV0_US       2
`define GMT_TDRV1_US       4
`define GMT_TDRV2_US       8
`define GMT_TDRV3_US       12
`define GMT_TDRV4_US       16
`define GMT_TDRV5_US       24
`define GMT_TDRV6_US       32
`define GMT_TDRV7_US       96
`define GMT_DEAD1_US       2
`define GMT_DEAD2_US       4
`define GMT_DEAD3_US       8

`endif

// file: design/gmt_pkg.sv
`include "gmt_params.svh"

package gmt_pkg;

	typedef enum logic [1:0] {
		GMT_MON_LATCHED  = 2'b00,
		GMT_MON_CYCLE    = 2'b01,
		GMT_MON_WARNING  = 2'b10,
		GMT_MON_DISABLED = 2'b11
	} gmt_mon_mode_t;

	typedef enum logic [1:0] {
		GMT_TS_IDLE  = 2'b00,
		GMT_TS_DRIVE = 2'b01,
		GMT_TS_DEAD  = 2'b10
	} gmt_timer_state_t;

	typedef struct packed {
		gmt_mon_mode_t gate_voltage_monitor_mode;
		logic          gate_fault_local_shutdown;
		logic          gate_threshold_select;
		logic          handshake_monitor_off;
		gmt_mon_mode_t drain_source_monitor_mode;
		logic          overcurrent_local_shutdown;
	} gmt_mode_cfg_t;

	function automatic logic [9:0] gmt_drive_cycles(input logic [2:0] code);
		case (code)
			3'h0: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV0_US));
			3'h1: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV1_US));
			3'h2: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV2_US));
			3'h3: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV3_US));
			3'h4: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV4_US));
			3'h5: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV5_US));
			3'h6: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV6_US));
			default: gmt_drive_cycles = 10'(`GMT_US2CYC(`GMT_TDRV7_US));
		endcase
	endfunction

	function automatic logic [9:0] gmt_dead_cycles(input logic [1:0] code);
		case (code)
			2'h0: gmt_dead_cycles = 10'h000;
			2'h1: gmt_dead_cycles = 10'(`GMT_US2CYC(`GMT_DEAD1_US));
			2'h2: gmt_dead_cycles = 10'(`GMT_US2CYC(`GMT_DEAD2_US));
			default: gmt_dead_cycles = 10'(`GMT_US2CYC(`GMT_DEAD3_US));
		endcase
	endfunction

endpackage

// file: design/gmt_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module gmt_sync3 #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	// =================================================================
	// accept a change once stages two and three agree
	always_comb begin
		nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= async_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign level_out = out_ff;

endmodule

`default_nettype wire

// file: design/gmt_bridge_timer.sv
`timescale 1ns/100ps
`default_nettype none

module gmt_bridge_timer (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pwm_level,
	input  wire logic       gate_settled,
	input  wire logic       handshake_off,
	input  wire logic [2:0] drive_code,
	input  wire logic [1:0] dead_code,
	output logic            high_on,
	output logic            low_on,
	output logic            blanking,
	output logic            edge_pulse
);

	gmt_pkg::gmt_timer_state_t state_ff;
	gmt_pkg::gmt_timer_state_t nxt_state;
	logic [9:0] cnt_ff;
	logic [9:0] nxt_cnt;
	logic       prev_ff;
	logic       hi_ff;
	logic       lo_ff;
	logic       nxt_hi;
	logic       nxt_lo;

	// =================================================================
	// edge, drive interval, extra dead time, then on-side
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_hi    = hi_ff;
		nxt_lo    = lo_ff;
		if (pwm_level != prev_ff) begin
			nxt_hi    = 1'b0;
			nxt_lo    = 1'b0;
			nxt_state = gmt_pkg::GMT_TS_DRIVE;
			nxt_cnt   = gmt_pkg::gmt_drive_cycles(drive_code) - 10'h001; // [RL9]
		end else begin
			case (state_ff)
				gmt_pkg::GMT_TS_DRIVE: begin
					// handshake ends the drive early unless switched off
					if (cnt_ff == 10'h000 || (!handshake_off && gate_settled)) begin // [RL5]
						nxt_state = gmt_pkg::GMT_TS_DEAD;
						nxt_cnt   = gmt_pkg::gmt_dead_cycles(dead_code); // [RL12]
					end else begin
						nxt_cnt = cnt_ff - 10'h001;
					end
				end
				gmt_pkg::GMT_TS_DEAD: begin
					if (cnt_ff == 10'h000) begin
						nxt_state = gmt_pkg::GMT_TS_IDLE;
						nxt_hi    = pwm_level;
						nxt_lo    = ~pwm_level;
					end else begin
						nxt_cnt = cnt_ff - 10'h001;
					end
				end
				gmt_pkg::GMT_TS_IDLE: begin
					nxt_cnt = 10'h000;
				end
				default: begin
					nxt_state = gmt_pkg::GMT_TS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= gmt_pkg::GMT_TS_IDLE;
			cnt_ff   <= 10'h000;
			prev_ff  <= 1'b0;
			hi_ff    <= 1'b0;
			lo_ff    <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			prev_ff  <= pwm_level;
			hi_ff    <= nxt_hi;
			lo_ff    <= nxt_lo;
		end
	end

	assign high_on    = hi_ff;
	assign low_on     = lo_ff;
	assign blanking   = (state_ff == gmt_pkg::GMT_TS_DRIVE); // [RL9]
	assign edge_pulse = (pwm_level != prev_ff);

endmodule

`default_nettype wire

// file: design/gmt_monitor_bank.sv
// Notes on behaviour
// [RL1] gate monitor mode: latched, cycle, warn, off
// [RL2] gate fault, global: all bridges off
// [RL3] gate fault, local: bridge or pair off
// [RL4] threshold select drives comparator level output
// [RL5] handshake off: drive time plus dead time
// [RL6] overcurrent monitor mode, same four encodings
// [RL7] overcurrent, global: all bridges off
// [RL8] overcurrent, local: bridge or pair off
// [RL9] drive code sets drive and blanking time
// [RL10] drive fields at 5-3, 2-0; top zero
// [RL11] dead-time fields, bridge one in top bits
// [RL12] dead code adds 0, 2, 4, 8 us
// [RL13] latched holds until cleared; cycle clears on edge
// [RL14] warning only flags; disabled does nothing
`include "gmt_params.svh"
`timescale 1ns/100ps
`default_nettype none

module gmt_monitor_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  pwm_in,
	input  wire logic [3:0]  gate_fault_in,
	input  wire logic [3:0]  oc_fault_in,
	input  wire logic [3:0]  gate_settled_in,
	output logic      [3:0]  high_side_on,
	output logic      [3:0]  low_side_on,
	output logic             gate_threshold_low,
	output logic             fault_irq
);

	// =================================================================
	// helpers
	function automatic logic [7:0] reg_hit(input logic [7:0] a);
		reg_hit = '0;
		if (a[1:0] == 2'b00) begin
			reg_hit[0] = (a[7:2] == `GMT_IDX_MODE_CFG);
			reg_hit[1] = (a[7:2] == `GMT_IDX_TDRV_A);
			reg_hit[2] = (a[7:2] == `GMT_IDX_TDRV_B);
			reg_hit[3] = (a[7:2] == `GMT_IDX_DEAD_CFG);
			reg_hit[4] = (a[7:2] == `GMT_IDX_STATUS);
			reg_hit[5] = (a[7:2] == `GMT_IDX_MASK);
			reg_hit[6] = (a[7:2] == `GMT_IDX_FAULT_CLR);
			reg_hit[7] = (a[7:2] == `GMT_IDX_PAIRING);
		end
	endfunction

	// widen active faults to the set of bridges to switch off
	function automatic logic [3:0] off_set(input logic [3:0] f, input logic local_sd, input logic pair);
		if (!local_sd) begin
			off_set = {4{|f}};
		end else if (pair) begin
			off_set = {{2{|f[3:2]}}, {2{|f[1:0]}}};
		end else begin
			off_set = f;
		end
	endfunction

	// next active fault state for one monitor
	function automatic logic [3:0] act_next(input logic [3:0] act, input logic [3:0] det,
		input gmt_pkg::gmt_mon_mode_t mode, input logic [3:0] sw_clr, input logic [3:0] edges);
		case (mode)
			gmt_pkg::GMT_MON_LATCHED: act_next = (act & ~sw_clr) | det;
			gmt_pkg::GMT_MON_CYCLE:   act_next = (act & ~edges) | det;
			default:                  act_next = 4'h0;
		endcase
	endfunction

	// =================================================================
	// pin inputs and bridge timers
	logic [3:0] pwm_s;
	logic [3:0] gate_fault_s;
	logic [3:0] oc_fault_s;
	logic [3:0] settled_s;
	logic [3:0] t_hi;
	logic [3:0] t_lo;
	logic [3:0] t_blank;
	logic [3:0] t_edge;
	logic [11:0] drive_codes;

	gmt_sync3 #(.W(16)) gmt_sync3_inst (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  ({pwm_in, gate_fault_in, oc_fault_in, gate_settled_in}),
		.level_out ({pwm_s, gate_fault_s, oc_fault_s, settled_s})
	);

	gmt_pkg::gmt_mode_cfg_t mode_ff;
	gmt_pkg::gmt_mode_cfg_t nxt_mode;
	logic [5:0] tdrv_a_ff;
	logic [5:0] tdrv_b_ff;
	logic [7:0] dead_ff;
	logic [7:0] status_ff;
	logic [7:0] mask_ff;
	logic       pair_ff;
	logic [3:0] act_gate_ff;
	logic [3:0] act_oc_ff;
	logic [31:0] prdata_ff;
	logic [3:0] hs_ff;
	logic [3:0] ls_ff;
	logic [5:0] nxt_tdrv_a;
	logic [5:0] nxt_tdrv_b;
	logic [7:0] nxt_dead;
	logic [7:0] nxt_status;
	logic [7:0] nxt_mask;
	logic       nxt_pair;
	logic [3:0] nxt_act_gate;
	logic [3:0] nxt_act_oc;
	logic [31:0] nxt_prdata;
	logic [3:0] nxt_hs;
	logic [3:0] nxt_ls;

	// bridge order 1..4 maps to index 0..3
	assign drive_codes = {tdrv_b_ff[2:0], tdrv_b_ff[5:3], tdrv_a_ff[2:0], tdrv_a_ff[5:3]}; // [RL10]

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_bridge
			gmt_bridge_timer gmt_bridge_timer_inst (
				.pclk          (pclk),
				.presetn       (presetn),
				.pwm_level     (pwm_s[gb]),
				.gate_settled  (settled_s[gb]),
				.handshake_off (mode_ff.handshake_monitor_off), // [RL5]
				.drive_code    (drive_codes[3*gb +: 3]), // [RL9]
				.dead_code     (dead_ff[6-2*gb +: 2]), // [RL11]
				.high_on       (t_hi[gb]),
				.low_on        (t_lo[gb]),
				.blanking      (t_blank[gb]),
				.edge_pulse    (t_edge[gb])
			);
		end
	endgenerate

	// =================================================================
	// bus decode and fault evaluation
	logic [7:0] hit;
	logic       acc;
	logic       wr;
	logic       rd_status;
	logic [3:0] gate_det;
	logic [3:0] oc_det;
	logic [3:0] gate_evt;
	logic [3:0] oc_evt;
	logic [3:0] sw_clr_gate;
	logic [3:0] sw_clr_oc;
	logic [3:0] shut;
	logic [7:0] rd_word;

	assign hit       = reg_hit(paddr);
	assign acc       = psel & penable;
	assign wr        = acc & pwrite;
	assign rd_status = acc & ~pwrite & hit[4];
	assign sw_clr_gate = (wr & hit[6]) ? pwdata[3:0] : 4'h0;
	assign sw_clr_oc   = (wr & hit[6]) ? pwdata[7:4] : 4'h0;

	// overcurrent ignored while its bridge is blanked
	assign gate_det = gate_fault_s;
	assign oc_det   = oc_fault_s & ~t_blank; // [RL9]
	assign gate_evt = (mode_ff.gate_voltage_monitor_mode == gmt_pkg::GMT_MON_DISABLED) ? 4'h0 : gate_det; // [RL14]
	assign oc_evt   = (mode_ff.drain_source_monitor_mode == gmt_pkg::GMT_MON_DISABLED) ? 4'h0 : oc_det; // [RL14]

	assign shut = off_set(act_gate_ff, mode_ff.gate_fault_local_shutdown, pair_ff) // [RL2] [RL3]
		| off_set(act_oc_ff, mode_ff.overcurrent_local_shutdown, pair_ff); // [RL7] [RL8]

	always_comb begin
		rd_word = 8'h00;
		case (1'b1)
			hit[0]: rd_word = mode_ff;
			hit[1]: rd_word = {2'b00, tdrv_a_ff}; // [RL10]
			hit[2]: rd_word = {2'b00, tdrv_b_ff}; // [RL10]
			hit[3]: rd_word = dead_ff;
			hit[4]: rd_word = status_ff;
			hit[5]: rd_word = mask_ff;
			hit[6]: rd_word = {act_oc_ff, act_gate_ff};
			hit[7]: rd_word = {7'h00, pair_ff};
			default: rd_word = 8'h00;
		endcase
	end

	// =================================================================
	// register file and fault state
	always_comb begin
		nxt_mode   = mode_ff;
		nxt_tdrv_a = tdrv_a_ff;
		nxt_tdrv_b = tdrv_b_ff;
		nxt_dead   = dead_ff;
		nxt_mask   = mask_ff;
		nxt_pair   = pair_ff;
		nxt_prdata = prdata_ff;
		if (wr) begin
			if (hit[0]) nxt_mode = gmt_pkg::gmt_mode_cfg_t'(pwdata[7:0]); // [RL1] [RL6]
			if (hit[1]) nxt_tdrv_a = pwdata[5:0]; // [RL10]
			if (hit[2]) nxt_tdrv_b = pwdata[5:0]; // [RL10]
			if (hit[3]) nxt_dead = pwdata[7:0]; // [RL11]
			if (hit[5]) nxt_mask = pwdata[7:0];
			if (hit[7]) nxt_pair = pwdata[`GMT_PAIR_BIT];
		end
		if (psel & ~penable) begin
			nxt_prdata = {24'h000000, rd_word};
		end
		// read clears, a new event in the same cycle still sets
		nxt_status = (status_ff & ~(prdata_ff[7:0] & {8{rd_status}})) | {oc_evt, gate_evt}; // [RL14]
		nxt_act_gate = act_next(act_gate_ff, gate_det, mode_ff.gate_voltage_monitor_mode,
			sw_clr_gate, t_edge); // [RL1] [RL13]
		nxt_act_oc = act_next(act_oc_ff, oc_det, mode_ff.drain_source_monitor_mode,
			sw_clr_oc, t_edge); // [RL6] [RL13]
		nxt_hs = t_hi & ~shut;
		nxt_ls = t_lo & ~shut;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff     <= gmt_pkg::gmt_mode_cfg_t'(`GMT_RST_MODE_CFG);
			tdrv_a_ff   <= 6'(`GMT_RST_TDRV);
			tdrv_b_ff   <= 6'(`GMT_RST_TDRV);
			dead_ff     <= `GMT_RST_DEAD;
			status_ff   <= 8'h00;
			mask_ff     <= `GMT_RST_MASK;
			pair_ff     <= 1'b0;
			act_gate_ff <= 4'h0;
			act_oc_ff   <= 4'h0;
			prdata_ff   <= 32'h00000000;
			hs_ff       <= 4'h0;
			ls_ff       <= 4'h0;
		end else begin
			mode_ff     <= nxt_mode;
			tdrv_a_ff   <= nxt_tdrv_a;
			tdrv_b_ff   <= nxt_tdrv_b;
			dead_ff     <= nxt_dead;
			status_ff   <= nxt_status;
			mask_ff     <= nxt_mask;
			pair_ff     <= nxt_pair;
			act_gate_ff <= nxt_act_gate;
			act_oc_ff   <= nxt_act_oc;
			prdata_ff   <= nxt_prdata;
			hs_ff       <= nxt_hs;
			ls_ff       <= nxt_ls;
		end
	end

	assign prdata             = prdata_ff;
	assign pready             = psel & penable;
	assign pslverr            = psel & penable & ~(|hit);
	assign high_side_on       = hs_ff;
	assign low_side_on        = ls_ff;
	assign gate_threshold_low = mode_ff.gate_threshold_select; // [RL4]
	assign fault_irq          = |(status_ff & mask_ff);

	// =================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_gate_global_off: assert property ((|act_gate_ff) && !mode_ff.gate_fault_local_shutdown // [RL2]
		|=> (high_side_on == 4'h0) && (low_side_on == 4'h0))
		else $error("gate fault did not switch off all bridges");
	a_gate_local_off: assert property (mode_ff.gate_fault_local_shutdown && !pair_ff && act_oc_ff == 4'h0 // [RL3]
		|=> ((high_side_on | low_side_on) & $past(act_gate_ff)) == 4'h0)
		else $error("local gate fault left its bridge driven");
	a_oc_global_off: assert property ((|act_oc_ff) && !mode_ff.overcurrent_local_shutdown // [RL7]
		|=> (high_side_on | low_side_on) == 4'h0)
		else $error("overcurrent did not switch off all bridges");
	a_oc_pair_off: assert property (act_oc_ff[3] && mode_ff.overcurrent_local_shutdown && pair_ff // [RL8]
		|=> !high_side_on[2] && !low_side_on[2])
		else $error("overcurrent did not switch off the paired bridge");
	a_latched_hold: assert property (act_gate_ff[1] // [RL13]
		&& mode_ff.gate_voltage_monitor_mode == gmt_pkg::GMT_MON_LATCHED && !(wr && hit[6])
		|=> act_gate_ff[1])
		else $error("latched fault cleared without software");
	a_cycle_clear: assert property (mode_ff.drain_source_monitor_mode == gmt_pkg::GMT_MON_CYCLE // [RL13]
		&& t_edge[3] && !oc_det[3] |=> !act_oc_ff[3])
		else $error("cycle fault not cleared by switching edge");
	a_warning_only: assert property (mode_ff.gate_voltage_monitor_mode == gmt_pkg::GMT_MON_WARNING // [RL14]
		&& gate_det[2] |=> status_ff[2] && !act_gate_ff[2])
		else $error("warning mode acted or did not flag");
	a_disabled_silent: assert property ( // [RL14]
		mode_ff.drain_source_monitor_mode == gmt_pkg::GMT_MON_DISABLED && !rd_status
		|=> $stable(status_ff[7:4]) && act_oc_ff == 4'h0)
		else $error("disabled monitor reported or acted");
	a_reserved_zero: assert property (psel && !penable && !pwrite && (hit[1] || hit[2]) // [RL10]
		|=> prdata[7:6] == 2'b00)
		else $error("reserved drive bits read nonzero");
	a_threshold_out: assert property (wr && hit[0] // [RL4]
		|=> gate_threshold_low == $past(pwdata[4]))
		else $error("threshold output did not follow write");
	a_irq_level: assert property ((({oc_evt, gate_evt} & mask_ff) != 8'h00) && !(wr && hit[5]) // [RL14]
		|=> fault_irq)
		else $error("unmasked event did not raise interrupt");

	c_latched_fault: cover property (mode_ff.gate_voltage_monitor_mode == gmt_pkg::GMT_MON_LATCHED
		&& $rose(act_gate_ff[1]));
	c_cycle_clear: cover property (mode_ff.drain_source_monitor_mode == gmt_pkg::GMT_MON_CYCLE
		&& $fell(act_oc_ff[3]));
	c_pair_shut: cover property (pair_ff && mode_ff.overcurrent_local_shutdown && (|act_oc_ff));
	c_irq: cover property ($rose(fault_irq));

endmodule

`default_nettype wire

// file: verification/tb_gmt_monitor_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "gmt_params.svh"

module tb_gmt_monitor_bank;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pwm_in = 4'h0;
	logic [3:0]  gate_fault_in = 4'h0;
	logic [3:0]  oc_fault_in = 4'h0;
	logic [3:0]  gate_settled_in = 4'h0;
	logic [3:0]  high_side_on;
	logic [3:0]  low_side_on;
	logic        gate_threshold_low;
	logic        fault_irq;
	logic [31:0] rd;
	logic        er;
	int          n_errors = 0;
	int          total_checks = 0;
	int          base;
	int          n;
	int          junk;
	int          drv_us[8] = '{2, 4, 8, 12, 16, 24, 32, 96};
	int          dead_us[4] = '{0, 2, 4, 8};

	localparam logic [7:0] a_mode = {`GMT_IDX_MODE_CFG, 2'b00};
	localparam logic [7:0] a_ta   = {`GMT_IDX_TDRV_A, 2'b00};
	localparam logic [7:0] a_tb   = {`GMT_IDX_TDRV_B, 2'b00};
	localparam logic [7:0] a_dead = {`GMT_IDX_DEAD_CFG, 2'b00};
	localparam logic [7:0] a_st   = {`GMT_IDX_STATUS, 2'b00};
	localparam logic [7:0] a_msk  = {`GMT_IDX_MASK, 2'b00};
	localparam logic [7:0] a_clr  = {`GMT_IDX_FAULT_CLR, 2'b00};
	localparam logic [7:0] a_pair = {`GMT_IDX_PAIRING, 2'b00};

	always #50 pclk = ~pclk;

	gmt_monitor_bank gmt_monitor_bank_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_in(pwm_in), .gate_fault_in(gate_fault_in), .oc_fault_in(oc_fault_in),
		.gate_settled_in(gate_settled_in), .high_side_on(high_side_on), .low_side_on(low_side_on),
		.gate_threshold_low(gate_threshold_low), .fault_irq(fault_irq)
	);

	// =====================================================================
	// reporting
	task test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task chk_int(input string nm, input int e, input int g);
		total_checks++;
		if (g != e) begin
			n_errors++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask

	// =====================================================================
	// apb master, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		apb(1'b0, a, 8'h00);
		chk_val(nm, {24'h0, e}, rd);
	endtask

	// =====================================================================
	// bridge output helpers
	task wait_hs(input logic [3:0] e, input string nm);
		int i;
		for (i = 0; i < 1200; i++) begin
			if (high_side_on === e) break;
			@(posedge pclk);
		end
		if (i == 1200) begin
			n_errors++;
			test_done();
		end
		chk_val(nm, {28'h0, e}, {28'h0, high_side_on});
	endtask

	task measure(input logic lvl, output int c);
		pwm_in <= {4{lvl}};
		c = 0;
		while (c < 2000 && !(high_side_on[0] === lvl && low_side_on[0] === ~lvl)) begin
			@(posedge pclk);
			c++;
		end
		if (c == 2000) begin
			n_errors++;
			test_done();
		end
	endtask

	task tm(input logic [2:0] c, input logic [1:0] d, output int r);
		wr(a_ta, {2'b00, c, 3'h0});
		wr(a_dead, {d, 6'h00});
		measure(1'b1, r);
		measure(1'b0, junk);
	endtask

	// =====================================================================
	// one fault pulse, then recovery by edge and by clear
	task flt(input logic g, input int b, input logic [7:0] cfg, input logic pr,
		input logic [3:0] eh, input logic [7:0] es, input logic lat);
		wr(a_pair, {7'h00, pr});
		wr(a_mode, cfg);
		if (g) gate_fault_in[b] <= 1'b1;
		else oc_fault_in[b] <= 1'b1;
		repeat (10) @(posedge pclk);
		gate_fault_in <= 4'h0;
		oc_fault_in <= 4'h0;
		repeat (10) @(posedge pclk);
		chk_val("hs_fault", {28'h0, eh}, {28'h0, high_side_on});
		chk_val("irq_set", {31'h0, |(es & 8'h02)}, {31'h0, fault_irq});
		rdc(a_st, es, "status");
		@(negedge pclk);
		chk_val("irq_clr", 32'h0, {31'h0, fault_irq});
		@(posedge pclk);
		pwm_in <= 4'h0;
		repeat (100) @(posedge pclk);
		pwm_in <= 4'hf;
		repeat (60) @(posedge pclk);
		wait_hs(lat ? eh : 4'hf, "hs_edge");
		wr(a_clr, 8'hff);
		wait_hs(4'hf, "hs_back");
		apb(1'b0, a_st, 8'h00);
	endtask

	// =====================================================================
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(a_mode, `GMT_RST_MODE_CFG, "mode_rst");
		rdc(a_ta, `GMT_RST_TDRV, "tdrv_a_rst");
		rdc(a_tb, `GMT_RST_TDRV, "tdrv_b_rst");
		rdc(a_dead, `GMT_RST_DEAD, "dead_rst");
		rdc(a_msk, `GMT_RST_MASK, "mask_rst");
		chk_val("ls_rst", 32'hf, {28'h0, low_side_on});
		wr(a_mode, 8'hff);
		rdc(a_mode, 8'hff, "mode_rw");
		chk_val("thr_1v", 32'h1, {31'h0, gate_threshold_low});
		wr(a_ta, 8'hff);
		rdc(a_ta, 8'h3f, "tdrv_a_rsvd");
		wr(a_tb, 8'hc5);
		rdc(a_tb, 8'h05, "tdrv_b_rsvd");
		wr(a_dead, 8'he4);
		rdc(a_dead, 8'he4, "dead_rw");
		apb(1'b0, 8'h04, 8'h00);
		chk_val("unmapped_err", 32'h1, {31'h0, er});
		chk_val("unmapped_rd", 32'h0, rd);
		apb(1'b1, 8'h61, 8'h00);
		chk_val("misalign_err", 32'h1, {31'h0, er});
		rdc(a_mode, 8'hff, "mode_kept");
		wr(a_mode, 8'h08);
		chk_val("thr_14v", 32'h0, {31'h0, gate_threshold_low});
		tm(3'h0, 2'h0, base);
		for (int d = 1; d < 4; d++) begin
			tm(3'h0, 2'(d), n);
			chk_int("dead_time", dead_us[d] * 10, n - base);
		end
		for (int c = 1; c < 8; c++) begin
			tm(3'(c), 2'h0, n);
			chk_int("drive_time", (drv_us[c] - drv_us[0]) * 10, n - base);
		end
		wr(a_mode, 8'h00);
		gate_settled_in <= 4'hf;
		tm(3'h7, 2'h0, n);
		chk_int("handshake_early", 1, int'(n < base + 100));
		gate_settled_in <= 4'h0;
		wr(a_ta, 8'h00);
		wr(a_tb, 8'h00);
		wr(a_dead, 8'h00);
		wr(a_msk, 8'h02);
		pwm_in <= 4'hf;
		wait_hs(4'hf, "all_on");
		apb(1'b0, a_st, 8'h00);
		flt(1'b1, 1, 8'h08, 1'b0, 4'h0, 8'h02, 1'b1);
		flt(1'b1, 1, 8'h28, 1'b0, 4'hd, 8'h02, 1'b1);
		flt(1'b1, 1, 8'h28, 1'b1, 4'hc, 8'h02, 1'b1);
		flt(1'b1, 0, 8'h68, 1'b0, 4'he, 8'h01, 1'b0);
		flt(1'b1, 2, 8'ha8, 1'b0, 4'hf, 8'h04, 1'b0);
		flt(1'b1, 2, 8'he8, 1'b0, 4'hf, 8'h00, 1'b0);
		flt(1'b0, 3, 8'h08, 1'b0, 4'h0, 8'h80, 1'b1);
		flt(1'b0, 3, 8'h09, 1'b0, 4'h7, 8'h80, 1'b1);
		flt(1'b0, 3, 8'h09, 1'b1, 4'h3, 8'h80, 1'b1);
		flt(1'b0, 3, 8'h0b, 1'b0, 4'h7, 8'h80, 1'b0);
		flt(1'b0, 3, 8'h0c, 1'b0, 4'hf, 8'h80, 1'b0);
		flt(1'b0, 3, 8'h0e, 1'b0, 4'hf, 8'h00, 1'b0);
		test_done();
	end
endmodule

`default_nettype wire
